// ---- shared/cms_pkg.sv ----
// shared constants, types and state layout for the counter mode sequencer
package cms_pkg;

    // ------------------------------------------------------------
    // counter geometry
    // ------------------------------------------------------------
    localparam int CMS_CNT_W = 16;                        // counter and reload width

    // ------------------------------------------------------------
    // register byte offsets (one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CMS_OFF_MODE   = 8'h00;        // configuration, read/write
    localparam logic [7:0] CMS_OFF_LOAD   = 8'h04;        // primary reload, read/write
    localparam logic [7:0] CMS_OFF_HOLD   = 8'h08;        // alternate reload, read/write
    localparam logic [7:0] CMS_OFF_COUNT  = 8'h0C;        // live counter, read only
    localparam logic [7:0] CMS_OFF_CMD    = 8'h10;        // command strobes, write only
    localparam logic [7:0] CMS_OFF_STATUS = 8'h14;        // sequencer state, read only

    // ------------------------------------------------------------
    // mode register field positions
    // ------------------------------------------------------------
    localparam int CMS_MODE_GCF_LSB = 0;                  // gate_control_field [2:0]
    localparam int CMS_MODE_SG_BIT  = 3;                  // special_gate_bit
    localparam int CMS_MODE_RS_BIT  = 4;                  // reload_source_bit
    localparam int CMS_MODE_REP_BIT = 5;                  // repetition_bit
    localparam int CMS_MODE_TOG_BIT = 6;                  // terminal toggle output enable

    // command register bits
    localparam int CMS_CMD_ARM_BIT    = 0;
    localparam int CMS_CMD_DISARM_BIT = 1;
    localparam int CMS_CMD_LOAD_BIT   = 2;

    // gate control field encodings
    localparam logic [2:0] CMS_GCF_NONE  = 3'h0;          // gate does not gate counting
    localparam logic [2:0] CMS_GCF_LEVEL = 3'h5;          // active-high gate level
    localparam logic [2:0] CMS_GCF_EDGE  = 3'h6;          // rising gate edge

    // reset values
    localparam logic [15:0] CMS_RST_CNT  = 16'h0000;
    localparam logic [2:0]  CMS_RST_GCF  = 3'h0;
    localparam logic [31:0] CMS_RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // ahb-lite transfer codes
    // ------------------------------------------------------------
    localparam logic [1:0] CMS_HTRANS_NONSEQ = 2'h2;
    localparam logic       CMS_HRESP_OKAY    = 1'b0;

    // ------------------------------------------------------------
    // decoded operating modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMS_M_IDLE = 4'b0000,   // unsupported combination, no counting
        CMS_M_D    = 4'b0001,   // free-running rate generator
        CMS_M_E    = 4'b0010,   // level-gated rate generator
        CMS_M_F    = 4'b0011,   // non-retriggerable one-shot
        CMS_M_G    = 4'b0100,   // software-triggered delayed pulse
        CMS_M_H    = 4'b0101,   // gated delayed pulse
        CMS_M_I    = 4'b0110,   // hardware-triggered delayed pulse strobe
        CMS_M_J    = 4'b0111,   // variable duty cycle, ungated
        CMS_M_K    = 4'b1000,   // variable duty cycle, level gated
        CMS_M_L    = 4'b1001,   // hardware-triggered delayed pulse one-shot
        CMS_M_N    = 4'b1010    // retriggerable level-gated strobe
    } cms_mode_e;

    // ahb-lite request side bundled together
    typedef struct packed {
        logic        hsel;
        logic [7:0]  haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } cms_ahb_req_s;

    // whole state of the sequencer
    typedef struct packed {
        logic [15:0] count;        // live down counter
        logic [15:0] load;         // primary reload
        logic [15:0] hold;         // alternate reload
        logic [2:0]  gcf;          // gate control field
        logic        sg;           // special gate
        logic        rs;           // reload source
        logic        rep;          // repetition
        logic        tog_en;       // terminal toggle output selected
        logic        armed;
        logic        running;      // triggered by a gate edge
        logic        in_tc;        // terminal count interval
        logic        alt_next;     // next reload comes from hold
        logic        tog;          // toggle flip-flop
        logic        retrig_pend;  // next qualified edge loads instead of counts
        logic        stop_pend;    // stop once terminal count ends
        logic        disarm_pend;  // disarm once terminal count ends
        logic        src_prev;
        logic        gate_prev;
        logic        ph_valid;     // data phase pending
        logic        ph_write;
        logic [7:0]  ph_addr;
        logic [31:0] rdata;
    } cms_state_s;

endpackage

// ---- hdl/cms_counter.sv ----
// counter mode sequencer for one 16-bit counter with an ahb-lite register slave
//
// Behaviour
// - mode from gate field plus three bits
// - terminal count reloads at its start
// - terminal count always counts next source edge
// - free-running rate mode ignores gate, repeats
// - free-running reload always from primary
// - level-gated rate counts only gate active
// - toggle output flips on each terminal count
// - one-shot starts on gate edge, stays armed
// - one-shot ignores gate until terminal count
// - delayed pulse: alternate, primary, then disarm
// - initial count delays, alternate sets width
// - gated delayed pulse counts while gate active
// - strobe starts on source edge after trigger
// - strobe disarms after second; rearm needed
// - gate edge while disarmed is discarded
// - duty cycle alternates alternate then primary
// - primary and alternate set low, high
// - gated duty cycle restarts alternation on arm
// - hardware one-shot: gate edge starts, alternation
// - strobe counts gate active, disarms at terminal
// - gate edge copies count to alternate register
// - retrigger: load first edge, count second
// - qualified edge is rising with gate active
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module cms_counter
    import cms_pkg::*;
(
    input  wire logic                clk_in,          // 10 mhz system clock
    input  wire logic                reset_n_in,      // synchronous, active low
    input  wire logic                ce_in,           // freezes all state when low
    input  wire cms_pkg::cms_ahb_req_s ahb_in,        // ahb-lite request bundle
    output logic [31:0]              hrdata_out,      // read data, from flop
    output logic                     hreadyout_out,   // low while frozen
    output logic                     hresp_out,       // always okay
    input  wire logic                source_in,       // count source, rising active
    input  wire logic                gate_in,         // gate, high active
    output logic                     terminal_count_out,       // high during tc
    output logic                     terminal_toggle_output_out // toggle flip-flop
);
    import cms_pkg::*;

    // ------------------------------------------------------------
    // state registers and next values
    // ------------------------------------------------------------
    cms_state_s s_q;              // registered state
    cms_state_s s_d;              // next state
    cms_mode_e  mode;             // decoded operating mode

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    // unsupported combinations fall to idle so the counter simply parks
    function automatic cms_mode_e decode_mode(input logic [2:0] g, input logic sg,
                                              input logic rs, input logic rep);
        cms_mode_e m;
        m = CMS_M_IDLE;
        case ({sg, rs, rep})
            3'b001: begin
                if (g == CMS_GCF_NONE) m = CMS_M_D;
                else if (g == CMS_GCF_LEVEL) m = CMS_M_E;
                else if (g == CMS_GCF_EDGE) m = CMS_M_F;
            end
            3'b010: begin
                if (g == CMS_GCF_NONE) m = CMS_M_G;
                else if (g == CMS_GCF_LEVEL) m = CMS_M_H;
                else if (g == CMS_GCF_EDGE) m = CMS_M_I;
            end
            3'b011: begin
                if (g == CMS_GCF_NONE) m = CMS_M_J;
                else if (g == CMS_GCF_LEVEL) m = CMS_M_K;
                else if (g == CMS_GCF_EDGE) m = CMS_M_L;
            end
            3'b100: begin
                if (g == CMS_GCF_LEVEL) m = CMS_M_N;
            end
            default: m = CMS_M_IDLE;
        endcase
        return m;
    endfunction

    assign mode = decode_mode(s_q.gcf, s_q.sg, s_q.rs, s_q.rep);

    // ------------------------------------------------------------
    // combinational helpers
    // ------------------------------------------------------------
    logic src_edge;               // rising source edge this cycle
    logic gate_edge;              // rising gate edge this cycle
    logic edge_mode;              // started by a gate edge
    logic level_mode;             // counts only while gate high
    logic count_ok;               // source edge that the counter takes
    logic tc_hit;                 // this counted edge enters terminal count
    logic addr_take;              // ahb address phase accepted
    logic wr_cmd;                 // command register written
    logic wr_hold;                // hold register written by software
    logic [31:0] wdata;           // write data of the data phase

    assign src_edge   = source_in & ~s_q.src_prev;
    assign gate_edge  = gate_in & ~s_q.gate_prev;
    assign edge_mode  = (mode == CMS_M_F) | (mode == CMS_M_I) | (mode == CMS_M_L);
    assign level_mode = (mode == CMS_M_E) | (mode == CMS_M_H) | (mode == CMS_M_K) |
                        (mode == CMS_M_N);
    assign addr_take  = ahb_in.hsel & ahb_in.hready & ahb_in.htrans[1];
    assign wdata      = ahb_in.hwdata;
    assign wr_cmd     = s_q.ph_valid & s_q.ph_write & (s_q.ph_addr == CMS_OFF_CMD);
    assign wr_hold    = s_q.ph_valid & s_q.ph_write & (s_q.ph_addr == CMS_OFF_HOLD);

    // decide whether this source edge is counted
    always_comb begin
        count_ok = 1'b0;
        if (src_edge) begin
            if (s_q.in_tc) begin
                count_ok = 1'b1;
            end else if (s_q.armed && mode != CMS_M_IDLE) begin
                if (edge_mode) begin
                    count_ok = s_q.running;
                end else if (level_mode) begin
                    count_ok = gate_in;
                end else begin
                    count_ok = 1'b1;
                end
            end
        end
    end

    // tc when the count would reach zero, unless a retrigger load swallows the edge
    assign tc_hit = count_ok & ~s_q.retrig_pend & (s_q.count == 16'h0001);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (ce_in) begin
            s_d.src_prev  = source_in;
            s_d.gate_prev = gate_in;

            // gate edge triggers the edge-started modes
            if (gate_edge && edge_mode && s_q.armed && !s_q.running) begin
                s_d.running = 1'b1;
            end
            // a gate edge to a disarmed counter changes nothing

            // counted source edge
            if (count_ok) begin
                if (s_q.in_tc) begin
                    // pending stop or disarm takes effect as tc ends
                    if (s_q.stop_pend) begin
                        s_d.running = 1'b0;
                    end
                    if (s_q.disarm_pend) begin
                        s_d.armed   = 1'b0;
                        s_d.running = 1'b0;
                    end
                    s_d.stop_pend   = 1'b0;
                    s_d.disarm_pend = 1'b0;
                end
                if (s_q.retrig_pend) begin
                    s_d.count       = s_q.load;
                    s_d.retrig_pend = 1'b0;
                    s_d.in_tc       = 1'b0;
                end else if (tc_hit) begin
                    s_d.in_tc = 1'b1;
                    if (s_q.tog_en) begin
                        s_d.tog = ~s_q.tog;
                    end
                    if (s_q.rs && s_q.alt_next) begin
                        s_d.count    = s_q.hold;
                        s_d.alt_next = 1'b0;
                    end else begin
                        s_d.count    = s_q.load;
                        s_d.alt_next = 1'b1;
                    end
                    case (mode)
                        CMS_M_F: s_d.stop_pend = 1'b1;
                        CMS_M_G, CMS_M_H: begin
                            s_d.disarm_pend = ~s_q.alt_next;
                        end
                        CMS_M_I: begin
                            s_d.disarm_pend = ~s_q.alt_next;
                        end
                        CMS_M_L: s_d.stop_pend = ~s_q.alt_next;
                        CMS_M_N: s_d.disarm_pend = 1'b1;
                        default: s_d.stop_pend = 1'b0;             // repeating modes
                    endcase
                end else begin
                    s_d.count = s_q.count - 16'h0001;
                    s_d.in_tc = 1'b0;
                end
            end

            // ahb data phase: writes land here, one cycle after the address
            if (s_q.ph_valid && s_q.ph_write) begin
                case (s_q.ph_addr)
                    CMS_OFF_MODE: begin
                        s_d.gcf    = wdata[CMS_MODE_GCF_LSB +: 3];
                        s_d.sg     = wdata[CMS_MODE_SG_BIT];
                        s_d.rs     = wdata[CMS_MODE_RS_BIT];
                        s_d.rep    = wdata[CMS_MODE_REP_BIT];
                        s_d.tog_en = wdata[CMS_MODE_TOG_BIT];
                    end
                    CMS_OFF_LOAD: s_d.load = wdata[15:0];
                    CMS_OFF_HOLD: s_d.hold = wdata[15:0];
                    default: s_d.ph_addr = s_q.ph_addr;            // command, read-only or unmapped
                endcase
            end

            // commands: software beats a same-cycle count on the counter
            if (wr_cmd) begin
                if (wdata[CMS_CMD_LOAD_BIT]) begin
                    s_d.count       = s_q.load;
                    s_d.retrig_pend = 1'b0;
                end
                if (wdata[CMS_CMD_ARM_BIT]) begin
                    s_d.armed    = 1'b1;
                    s_d.alt_next = 1'b1;
                    if (!s_q.armed) begin
                        s_d.running = 1'b0;
                    end
                end
                if (wdata[CMS_CMD_DISARM_BIT]) begin
                    if (s_q.in_tc && !count_ok) begin
                        s_d.disarm_pend = 1'b1;
                    end else begin
                        s_d.armed   = 1'b0;
                        s_d.running = 1'b0;
                    end
                end
            end

            // retrigger in the strobe mode, placed last so that a same-cycle
            // counted edge or load command cannot swallow the new request
            if (gate_edge && mode == CMS_M_N && s_q.armed) begin
                s_d.hold        = s_q.count;
                s_d.retrig_pend = 1'b1;
            end

            // ahb address phase and registered read data
            s_d.ph_valid = addr_take;
            s_d.ph_write = ahb_in.hwrite;
            s_d.ph_addr  = ahb_in.haddr;
            if (addr_take && !ahb_in.hwrite) begin
                case (ahb_in.haddr)
                    CMS_OFF_MODE:   s_d.rdata = {25'h0000000, s_q.tog_en, s_q.rep,
                                                 s_q.rs, s_q.sg, s_q.gcf};
                    CMS_OFF_LOAD:   s_d.rdata = {16'h0000, s_q.load};
                    CMS_OFF_HOLD:   s_d.rdata = {16'h0000, s_q.hold};
                    CMS_OFF_COUNT:  s_d.rdata = {16'h0000, s_q.count};
                    CMS_OFF_STATUS: s_d.rdata = {24'h000000, s_q.retrig_pend,
                                                 s_q.alt_next, s_q.tog, s_q.in_tc,
                                                 s_q.running, s_q.armed, 2'h0} >> 2;
                    default:        s_d.rdata = CMS_RST_WORD;      // unmapped reads zero
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // synchronous reset loads constants only
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.alt_next <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata_out                 = s_q.rdata;
    assign hreadyout_out              = ce_in;    // a frozen slave must stall the bus
    assign hresp_out                  = CMS_HRESP_OKAY;
    assign terminal_count_out         = s_q.in_tc;
    assign terminal_toggle_output_out = s_q.tog;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    logic quiet;                  // no software write to the counter this cycle
    assign quiet = ~wr_cmd & ~(s_q.ph_valid & s_q.ph_write);

    property p_free_reload;
        (ce_in && quiet && mode == CMS_M_D && tc_hit) |=> s_q.count == $past(s_q.load);
    endproperty
    a_free_reload: assert property (p_free_reload)
        else $error("free-running mode did not reload from primary");

    property p_tc_counts;
        (ce_in && quiet && s_q.in_tc && src_edge && !s_q.retrig_pend &&
         s_q.count != 16'h0001) |=> (s_q.count == $past(s_q.count) - 16'h0001) && !s_q.in_tc;
    endproperty
    a_tc_counts: assert property (p_tc_counts)
        else $error("edge during terminal count was not counted");

    property p_gate_ignored;
        (ce_in && quiet && mode == CMS_M_D && s_q.armed && src_edge && !gate_in &&
         s_q.count > 16'h0001) |=> s_q.count == $past(s_q.count) - 16'h0001;
    endproperty
    a_gate_ignored: assert property (p_gate_ignored)
        else $error("gate stopped the free-running counter");

    property p_level_hold;
        (ce_in && quiet && mode == CMS_M_E && !s_q.in_tc && !gate_in) |=> $stable(s_q.count);
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("level-gated counter moved with gate low");

    property p_toggle;
        (ce_in && s_q.tog_en && tc_hit) |=> s_q.tog != $past(s_q.tog);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle output did not flip at terminal count");

    property p_disarmed_edge;
        (ce_in && edge_mode && !s_q.armed && gate_edge && !wr_cmd) |=> !s_q.running;
    endproperty
    a_disarmed_edge: assert property (p_disarmed_edge)
        else $error("gate edge started a disarmed counter");

    property p_first_alt;
        (ce_in && quiet && mode == CMS_M_G && tc_hit && s_q.alt_next)
            |=> s_q.count == $past(s_q.hold) && s_q.in_tc && !s_q.alt_next;
    endproperty
    a_first_alt: assert property (p_first_alt)
        else $error("first terminal count did not reload from alternate");

    property p_retrig_copy;
        (ce_in && !wr_hold && mode == CMS_M_N && s_q.armed && gate_edge)
            |=> s_q.hold == $past(s_q.count) && s_q.retrig_pend;
    endproperty
    a_retrig_copy: assert property (p_retrig_copy)
        else $error("retrigger did not copy the count");

    property p_retrig_load;
        (ce_in && quiet && s_q.retrig_pend && src_edge && gate_in && !gate_edge &&
         mode == CMS_M_N && (s_q.armed || s_q.in_tc))
            |=> s_q.count == $past(s_q.load) && !s_q.retrig_pend;
    endproperty
    a_retrig_load: assert property (p_retrig_load)
        else $error("retrigger did not load primary on first qualified edge");

    property p_strobe_disarm;
        (ce_in && quiet && mode == CMS_M_N && tc_hit && !s_q.in_tc) |=> s_q.disarm_pend &&
            (s_q.armed == $past(s_q.armed));
    endproperty
    a_strobe_disarm: assert property (p_strobe_disarm)
        else $error("strobe mode did not schedule disarm at terminal count");

    // edge-started modes hold their count until the trigger has been seen
    property p_wait_trigger;
        (ce_in && quiet && edge_mode && s_q.armed && !s_q.running && !s_q.in_tc &&
         src_edge) |=> $stable(s_q.count);
    endproperty
    a_wait_trigger: assert property (p_wait_trigger)
        else $error("edge-started counter moved before its trigger");

    // reload happens as terminal count begins, not when it ends
    property p_tc_reload;
        (ce_in && quiet && tc_hit && !s_q.rs) |=> s_q.in_tc && s_q.count == $past(s_q.load);
    endproperty
    a_tc_reload: assert property (p_tc_reload)
        else $error("terminal count did not reload at its start");

    // every arm restarts the alternation on the alternate register
    property p_arm_alt;
        (ce_in && wr_cmd && wdata[CMS_CMD_ARM_BIT] && !wdata[CMS_CMD_DISARM_BIT])
            |=> s_q.armed && s_q.alt_next;
    endproperty
    a_arm_alt: assert property (p_arm_alt)
        else $error("arm command did not restart the alternation");

endmodule

// ---- sim/cms_host.sv ----
// host model: ahb-lite master issuing counter commands
`timescale 1ns/1ps
module cms_host
    import cms_pkg::*;
(
    input  wire logic             clk_in,    // bus clock
    input  wire logic             hready_in, // shared bus ready
    input  wire logic [31:0]      hrdata_in, // slave read data
    output cms_pkg::cms_ahb_req_s req_out    // request bundle
);
    cms_ahb_req_s r_q = '0;                  // held request, ready field unused
    // ready is the slave's own, so loop it into the bundle
    always_comb begin
        req_out        = r_q;
        req_out.hready = hready_in;
    end
    // one word transfer; caller enters just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        r_q <= '{1'b1, a, CMS_HTRANS_NONSEQ, wr, 3'h2, r_q.hwdata, 1'b0};
        @(posedge clk_in);
        while (hready_in !== 1'b1) @(posedge clk_in);
        r_q.htrans <= 2'h0;
        r_q.hwdata <= wd;
        @(posedge clk_in);
        while (hready_in !== 1'b1) @(posedge clk_in);
        rd = hrdata_in;
    endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the counter mode sequencer
`timescale 1ns/1ps
module tb_top;
    import cms_pkg::*;
    logic         clk_in      = 1'b0;  // 10 mhz clock
    logic         reset_n     = 1'b0;  // synchronous reset, active low
    logic         source      = 1'b0;  // count source
    logic         gate        = 1'b0;  // gate level
    logic         ce          = 1'b1;  // clock enable
    logic         resp;                // bus response
    logic         rdy;                 // bus ready
    logic         tc;                  // terminal count level
    logic         tog;                 // toggle output
    logic [31:0]  rdata;               // read data
    logic [31:0]  tmp;                 // last read word
    cms_ahb_req_s req;                 // request bundle
    int           errors      = 0;
    int           check_count = 0;
    int           cycles      = 0;
    always #50 clk_in = ~clk_in;
    cms_host host (.clk_in(clk_in), .hready_in(rdy), .hrdata_in(rdata), .req_out(req));
    cms_counter dut (.clk_in(clk_in), .reset_n_in(reset_n), .ce_in(ce), .ahb_in(req),
        .hrdata_out(rdata), .hreadyout_out(rdy), .hresp_out(resp), .source_in(source),
        .gate_in(gate), .terminal_count_out(tc), .terminal_toggle_output_out(tog));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, tmp);
    endtask
    // one read with its expected word; the response must be okay
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, tmp);
        chk(tmp, exp);
        chk({31'h0, resp}, 32'h0);
    endtask
    // n source edges, each a one-cycle high pulse
    task automatic step(input int n, input logic [15:0] exp);
        repeat (n) begin
            source <= 1'b1;
            @(posedge clk_in);
            source <= 1'b0;
            @(posedge clk_in);
        end
        rd(CMS_OFF_COUNT, {16'h0000, exp});
    endtask
    // mode, reloads, load plus arm, then count
    task automatic run(input logic [7:0] m, input logic [15:0] ld, input logic [15:0] hd,
                       input int n, input logic [15:0] exp);
        wr(CMS_OFF_MODE, {24'h0, m});
        wr(CMS_OFF_LOAD, {16'h0, ld});
        wr(CMS_OFF_HOLD, {16'h0, hd});
        wr(CMS_OFF_CMD, 32'h0000_0005);
        step(n, exp);
    endtask
    // hang guard, far above the fewer than two hundred cycles needed
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_in);
        reset_n <= 1'b1;
        @(posedge clk_in);
        run(8'h60, 16'h0003, 16'h0000, 3, 16'h0003);
        chk({31'h0, tc}, 32'h1);
        step(1, 16'h0002);
        ce <= 1'b0;                                    // a frozen edge must not count
        source <= 1'b1;
        @(posedge clk_in);
        source <= 1'b0;
        @(posedge clk_in);
        ce <= 1'b1;
        @(posedge clk_in);
        rd(CMS_OFF_COUNT, 32'h0000_0002);
        chk({31'h0, tog}, 32'h1);
        run(8'h25, 16'h0003, 16'h0000, 2, 16'h0003);
        run(8'h70, 16'h0002, 16'h0004, 3, 16'h0003);
        step(4, 16'h0001);
        run(8'h50, 16'h0002, 16'h0003, 3, 16'h0002);
        step(3, 16'h0001);
        step(2, 16'h0001);
        wr(CMS_OFF_MODE, 32'h0000_0026);
        wr(CMS_OFF_LOAD, 32'h0000_0002);
        wr(CMS_OFF_CMD, 32'h0000_0004);
        gate <= 1'b1;
        @(posedge clk_in);
        gate <= 1'b0;
        wr(CMS_OFF_CMD, 32'h0000_0001);
        step(1, 16'h0002);
        gate <= 1'b1;
        @(posedge clk_in);
        step(3, 16'h0001);
        step(2, 16'h0001);
        run(8'h0D, 16'h0003, 16'h0000, 1, 16'h0002);
        gate <= 1'b0;
        @(posedge clk_in);
        gate <= 1'b1;
        @(posedge clk_in);
        rd(CMS_OFF_HOLD, 32'h0000_0002);
        step(1, 16'h0003);
        step(1, 16'h0002);
        step(2, 16'h0003);
        chk({31'h0, tc}, 32'h1);
        step(2, 16'h0002);
        summarize();
    end
endmodule
